// [include/capture_timer_setup_map.svh]
// Constants for the capture/compare timer: offsets, fields, resets, codes.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
//
// Summary of operation
// - Clearing the standby bit makes timer active
// - Priority level zero disables timer interrupt
// - Request bit reads one while interrupt pending
// - Channel enable zero blocks channel flag interrupt
// - Wrap enable zero blocks wrap flag interrupt
// - Run bit zero stops the counter
// - Switch zero selects slow oscillator divided 128
// - Control 00 captures counter on rising edge
`ifndef CAPTURE_TIMER_SETUP_MAP_SVH
`define CAPTURE_TIMER_SETUP_MAP_SVH

// Register byte offsets
`define CTS_OFF_STANDBY   8'h00
`define CTS_OFF_IRQ_CTRL  8'h04
`define CTS_OFF_IRQ_EN    8'h08
`define CTS_OFF_MODE      8'h0c
`define CTS_OFF_COUNT_CTL 8'h10
`define CTS_OFF_FLAGS     8'h14
`define CTS_OFF_IO_CTL    8'h18
`define CTS_OFF_COUNTER   8'h1c
`define CTS_OFF_GEN_A     8'h20
`define CTS_OFF_GEN_B     8'h24
`define CTS_OFF_GEN_C     8'h28
`define CTS_OFF_GEN_D     8'h2c

// Field positions
`define CTS_BIT_STANDBY   5
`define CTS_BIT_PENDING   3
`define CTS_BIT_WRAP_EN   7
`define CTS_BIT_RUN       7
`define CTS_BIT_BUFFER    4
`define CTS_BIT_CLEAR_A   7
`define CTS_BIT_CAP_MODE  2
`define CTS_BIT_SWITCH    3
`define CTS_FLAG_A        0
`define CTS_FLAG_B        1
`define CTS_FLAG_C        2
`define CTS_FLAG_D        3
`define CTS_FLAG_WRAP     4

// Reset values
`define CTS_RST_STANDBY   1'b1
`define CTS_RST_LEVEL     3'h0
`define CTS_RST_BYTE      8'h00
`define CTS_RST_WORD      16'h0000
`define CTS_RST_FLAGS     5'h00
`define CTS_RST_PRE       5'h00

// Codes and counts
`define CTS_LEVEL_OFF     3'h0
`define CTS_EDGE_RISE     2'h0
`define CTS_EDGE_FALL     2'h1
`define CTS_SRC_DIV1      3'h0
`define CTS_SRC_DIV2      3'h1
`define CTS_SRC_DIV4      3'h2
`define CTS_SRC_DIV8      3'h3
`define CTS_SRC_DIV32     3'h4
`define CTS_WORD_MAX      16'hffff
`define CTS_DIV_HALF      6'h3f
`define CTS_DIV_ZERO      6'h00

`endif

// [include/capture_timer_setup_pkg.sv]
// Types for the capture/compare timer.
// Assumes the constants header is compiled alongside.
package capture_timer_setup_pkg;

   // Two-stage synchroniser state
   typedef struct packed {
      logic stage1;
      logic stage2;
   } sync_state_t;

   // Divide-by-128 state
   typedef struct packed {
      logic [5:0] edge_cnt;
      logic       level;
      logic       osc_prev;
   } div_state_t;

   // Timer core state
   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic        standby;
      logic [2:0]  level;
      logic        pending;
      logic [7:0]  irq_en;
      logic [7:0]  mode;
      logic [7:0]  count_ctl;
      logic [7:0]  io_ctl;
      logic [4:0]  flags;
      logic [15:0] counter;
      logic [15:0] gen_a;
      logic [15:0] gen_b;
      logic [15:0] gen_c;
      logic [15:0] gen_d;
      logic [4:0]  pre;
      logic        cap_prev;
      logic        irq;
   } timer_state_t;

endpackage

// [design/level_sync.sv]
// Two flip-flop synchroniser for one level from another clock domain.
// Assumes the input toggles slower than clk_sys.
`timescale 1ns/10ps
`default_nettype none
module level_sync
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Level in and out
   input  wire logic async_in,
   output logic      sync_out
);

   capture_timer_setup_pkg::sync_state_t st_reg;
   capture_timer_setup_pkg::sync_state_t st_next;

   // Shift through two stages
   always_comb
   begin
      st_next        = st_reg;
      st_next.stage1 = async_in;
      st_next.stage2 = st_reg.stage1;
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign sync_out = st_reg.stage2;

endmodule
`default_nettype wire

// [design/osc_div128.sv]
// Divides a synchronised slow oscillator level by 128.
// Assumes the oscillator runs well below half of clk_sys.
`include "capture_timer_setup_map.svh"
`timescale 1ns/10ps
`default_nettype none
module osc_div128
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Oscillator in, divided level out
   input  wire logic osc_level,
   output logic      div_level
);

   capture_timer_setup_pkg::div_state_t st_reg;
   capture_timer_setup_pkg::div_state_t st_next;

   // Toggle the output every 64 rising oscillator edges
   always_comb
   begin
      st_next          = st_reg;
      st_next.osc_prev = osc_level;
      if (osc_level && !st_reg.osc_prev)
      begin
         if (st_reg.edge_cnt == `CTS_DIV_HALF)
         begin
            st_next.edge_cnt = `CTS_DIV_ZERO;
            st_next.level    = !st_reg.level;
         end
         else
            st_next.edge_cnt = st_reg.edge_cnt + 6'h01;
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign div_level = st_reg.level;

endmodule
`default_nettype wire

// [design/capture_timer_setup.sv]
// Capture/compare timer with Wishbone register slave and interrupt request.
// Assumes a classic Wishbone master on clk_sys; oscillator and pin are async.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`include "capture_timer_setup_map.svh"
`timescale 1ns/10ps
`default_nettype none
module capture_timer_setup
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Asynchronous inputs
   input  wire logic        slow_osc_clk,
   input  wire logic        capture_pin,
   // Interrupt request
   output logic             irq_request
);

   capture_timer_setup_pkg::timer_state_t s_reg;
   capture_timer_setup_pkg::timer_state_t s_next;

   logic       osc_sync;
   logic       pin_sync;
   logic       slow_osc_div128;

   // Synchronise both external levels
   level_sync u_osc_sync
   (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in (slow_osc_clk),
      .sync_out (osc_sync)
   );

   level_sync u_pin_sync
   (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in (capture_pin),
      .sync_out (pin_sync)
   );

   // Slow oscillator divided by 128
   osc_div128 u_div
   (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .osc_level (osc_sync),
      .div_level (slow_osc_div128)
   );

   // Helper terms
   logic        req;
   logic        wr;
   logic [1:0]  edge_sel;
   logic        cap_src;
   logic        cap_edge;
   logic        tick;
   logic        counting;
   logic        cap_mode;
   logic        ev_a;
   logic [4:0]  flag_set;
   logic [4:0]  flag_clr;
   logic [4:0]  src_en;
   logic        set_ev;

   // Bus request and write strobe, write lands on the ack edge
   assign req = wb_cyc_i && wb_stb_i && !s_reg.ack;
   assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack;

   // Capture input selection and edge detect
   assign edge_sel = s_reg.io_ctl[1:0];
   assign cap_mode = s_reg.io_ctl[`CTS_BIT_CAP_MODE];
   assign cap_src  = s_reg.io_ctl[`CTS_BIT_SWITCH] ? pin_sync : slow_osc_div128;
   always_comb
   begin
      if (edge_sel == `CTS_EDGE_RISE)
         cap_edge = cap_src && !s_reg.cap_prev;
      else if (edge_sel == `CTS_EDGE_FALL)
         cap_edge = !cap_src && s_reg.cap_prev;
      else
         cap_edge = cap_src != s_reg.cap_prev;
   end

   // Count source prescaler tick
   always_comb
   begin
      unique case (s_reg.count_ctl[6:4])
         `CTS_SRC_DIV1:  tick = 1'b1;
         `CTS_SRC_DIV2:  tick = s_reg.pre[0];
         `CTS_SRC_DIV4:  tick = &s_reg.pre[1:0];
         `CTS_SRC_DIV8:  tick = &s_reg.pre[2:0];
         `CTS_SRC_DIV32: tick = &s_reg.pre;
         default:        tick = 1'b1;
      endcase
   end

   // Counter runs only when active and started
   assign counting = !s_reg.standby && s_reg.mode[`CTS_BIT_RUN] && tick;

   // Channel events
   always_comb
   begin
      flag_set = '0;
      if (!s_reg.standby)
      begin
         if (cap_mode)
            flag_set[`CTS_FLAG_A] = cap_edge;
         else
            flag_set[`CTS_FLAG_A] = counting && (s_reg.counter == s_reg.gen_a);
         flag_set[`CTS_FLAG_B] = counting && (s_reg.counter == s_reg.gen_b);
         flag_set[`CTS_FLAG_C] = counting && !s_reg.mode[`CTS_BIT_BUFFER]
                                 && (s_reg.counter == s_reg.gen_c);
         flag_set[`CTS_FLAG_D] = counting && (s_reg.counter == s_reg.gen_d);
         flag_set[`CTS_FLAG_WRAP] = counting && (s_reg.counter == `CTS_WORD_MAX);
      end
   end
   assign ev_a = flag_set[`CTS_FLAG_A];

   // Flags cleared by writing ones
   assign flag_clr = (wr && wb_adr_i == `CTS_OFF_FLAGS && wb_sel_i[0]) ?
                     wb_dat_i[4:0] : 5'h00;

   // Enabled sources and request event
   assign src_en = {s_reg.irq_en[`CTS_BIT_WRAP_EN], s_reg.irq_en[3:0]};
   assign set_ev = (|(flag_set & src_en)) && (s_reg.level != `CTS_LEVEL_OFF);

   // Next state
   always_comb
   begin
      s_next         = s_reg;
      s_next.ack     = req;
      s_next.pre     = s_reg.pre + 5'h01;
      s_next.cap_prev = cap_src;

      // Read data, captured with the request
      if (req)
      begin
         s_next.rdata = 32'h0000_0000;
         unique case (wb_adr_i)
            `CTS_OFF_STANDBY:   s_next.rdata[`CTS_BIT_STANDBY] = s_reg.standby;
            `CTS_OFF_IRQ_CTRL:  s_next.rdata[3:0] = {s_reg.pending, s_reg.level};
            `CTS_OFF_IRQ_EN:    s_next.rdata[7:0] = s_reg.irq_en;
            `CTS_OFF_MODE:      s_next.rdata[7:0] = s_reg.mode;
            `CTS_OFF_COUNT_CTL: s_next.rdata[7:0] = s_reg.count_ctl;
            `CTS_OFF_FLAGS:     s_next.rdata[4:0] = s_reg.flags;
            `CTS_OFF_IO_CTL:    s_next.rdata[7:0] = s_reg.io_ctl;
            `CTS_OFF_COUNTER:   s_next.rdata[15:0] = s_reg.counter;
            `CTS_OFF_GEN_A:     s_next.rdata[15:0] = s_reg.gen_a;
            `CTS_OFF_GEN_B:     s_next.rdata[15:0] = s_reg.gen_b;
            `CTS_OFF_GEN_C:     s_next.rdata[15:0] = s_reg.gen_c;
            `CTS_OFF_GEN_D:     s_next.rdata[15:0] = s_reg.gen_d;
            default:            s_next.rdata = 32'h0000_0000;
         endcase
      end

      // Counter and channel registers
      if (counting)
         s_next.counter = s_reg.counter + 16'h0001;
      if (ev_a && cap_mode)
      begin
         s_next.gen_a = s_reg.counter;
         if (s_reg.mode[`CTS_BIT_BUFFER])
            s_next.gen_c = s_reg.gen_a;
      end
      if (ev_a && s_reg.count_ctl[`CTS_BIT_CLEAR_A])
         s_next.counter = `CTS_RST_WORD;

      // Register writes
      if (wr)
      begin
         unique case (wb_adr_i)
            `CTS_OFF_STANDBY:
               if (wb_sel_i[0]) s_next.standby = wb_dat_i[`CTS_BIT_STANDBY];
            `CTS_OFF_IRQ_CTRL:
               if (wb_sel_i[0]) s_next.level = wb_dat_i[2:0];
            `CTS_OFF_IRQ_EN:
               if (wb_sel_i[0]) s_next.irq_en = wb_dat_i[7:0] & 8'h8f;
            `CTS_OFF_MODE:
               if (wb_sel_i[0]) s_next.mode = wb_dat_i[7:0];
            `CTS_OFF_COUNT_CTL:
               if (wb_sel_i[0]) s_next.count_ctl = wb_dat_i[7:0];
            `CTS_OFF_IO_CTL:
               if (wb_sel_i[0]) s_next.io_ctl = wb_dat_i[7:0];
            `CTS_OFF_COUNTER:
            begin
               if (wb_sel_i[0]) s_next.counter[7:0]  = wb_dat_i[7:0];
               if (wb_sel_i[1]) s_next.counter[15:8] = wb_dat_i[15:8];
            end
            `CTS_OFF_GEN_A:
            begin
               if (wb_sel_i[0]) s_next.gen_a[7:0]  = wb_dat_i[7:0];
               if (wb_sel_i[1]) s_next.gen_a[15:8] = wb_dat_i[15:8];
            end
            `CTS_OFF_GEN_B:
            begin
               if (wb_sel_i[0]) s_next.gen_b[7:0]  = wb_dat_i[7:0];
               if (wb_sel_i[1]) s_next.gen_b[15:8] = wb_dat_i[15:8];
            end
            `CTS_OFF_GEN_C:
            begin
               if (wb_sel_i[0]) s_next.gen_c[7:0]  = wb_dat_i[7:0];
               if (wb_sel_i[1]) s_next.gen_c[15:8] = wb_dat_i[15:8];
            end
            `CTS_OFF_GEN_D:
            begin
               if (wb_sel_i[0]) s_next.gen_d[7:0]  = wb_dat_i[7:0];
               if (wb_sel_i[1]) s_next.gen_d[15:8] = wb_dat_i[15:8];
            end
            default:
               s_next.rdata = s_next.rdata;
         endcase
      end

      // Flags: set wins over clear
      s_next.flags = (s_reg.flags & ~flag_clr) | flag_set;

      // Pending request held while an enabled flag stays set
      s_next.pending = set_ev || (s_reg.pending && (|(s_next.flags & src_en))
                       && (s_next.level != `CTS_LEVEL_OFF));
      s_next.irq     = s_next.pending;
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg           <= '0;
         s_reg.standby   <= `CTS_RST_STANDBY;
         s_reg.level     <= `CTS_RST_LEVEL;
         s_reg.flags     <= `CTS_RST_FLAGS;
         s_reg.pre       <= `CTS_RST_PRE;
      end
      else
         s_reg <= s_next;
   end

   // Outputs straight from flip-flops
   assign wb_ack_o    = s_reg.ack;
   assign wb_dat_o    = s_reg.rdata;
   assign irq_request = s_reg.irq;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_standby_frozen;
      (s_reg.standby && !(wr && wb_adr_i == `CTS_OFF_COUNTER)) |=> $stable(s_reg.counter);
   endproperty
   a_standby_frozen: assert property (p_standby_frozen)
      else $error("counter moved in standby");

   property p_level_zero;
      (s_reg.level == `CTS_LEVEL_OFF && !s_reg.pending) |=> !s_reg.pending;
   endproperty
   a_level_zero: assert property (p_level_zero)
      else $error("request raised at level zero");

   property p_pending_read;
      (wb_ack_o && !wb_we_i && wb_adr_i == `CTS_OFF_IRQ_CTRL)
         |-> wb_dat_o[`CTS_BIT_PENDING] == $past(s_reg.pending);
   endproperty
   a_pending_read: assert property (p_pending_read)
      else $error("request bit read wrong");

   property p_chan_masked;
      (!s_reg.pending && ((flag_set[3:0] & s_reg.irq_en[3:0]) == 4'h0)
         && !flag_set[`CTS_FLAG_WRAP]) |=> !s_reg.pending;
   endproperty
   a_chan_masked: assert property (p_chan_masked)
      else $error("masked channel raised request");

   property p_wrap_masked;
      (!s_reg.pending && flag_set == 5'h10 && !s_reg.irq_en[`CTS_BIT_WRAP_EN])
         |=> !s_reg.pending;
   endproperty
   a_wrap_masked: assert property (p_wrap_masked)
      else $error("masked wrap raised request");

   property p_run_stop;
      (!s_reg.mode[`CTS_BIT_RUN] && !ev_a && !(wr && wb_adr_i == `CTS_OFF_COUNTER))
         |=> $stable(s_reg.counter);
   endproperty
   a_run_stop: assert property (p_run_stop)
      else $error("counter moved while stopped");

   property p_src_select;
      !s_reg.io_ctl[`CTS_BIT_SWITCH] |=> s_reg.cap_prev == $past(slow_osc_div128);
   endproperty
   a_src_select: assert property (p_src_select)
      else $error("capture source not divided oscillator");

   property p_capture;
      (!s_reg.standby && cap_mode && edge_sel == `CTS_EDGE_RISE && cap_src
         && !s_reg.cap_prev && !(wr && wb_adr_i == `CTS_OFF_GEN_A))
         |=> s_reg.gen_a == $past(s_reg.counter) && s_reg.flags[`CTS_FLAG_A];
   endproperty
   a_capture: assert property (p_capture)
      else $error("rising edge not captured");

   property p_raise;
      set_ev |=> s_reg.pending && irq_request;
   endproperty
   a_raise: assert property (p_raise)
      else $error("enabled event did not raise request");

   property p_ack_single;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_single: assert property (p_ack_single)
      else $error("ack longer than one cycle");

endmodule
`default_nettype wire

// [tb/test_capture_timer_setup.sv]
// Self-checking bench for the capture/compare timer register slave.
// Assumes the design files and the constants header are compiled first.
`include "capture_timer_setup_map.svh"
`timescale 1ns/10ps
`default_nettype none
module test_capture_timer_setup;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h3;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        slow_osc_clk = 1'b0;
   logic        capture_pin = 1'b0;
   logic        irq_request;
   logic        osc_run = 1'b0;
   logic        pin_run = 1'b0;
   int          tick = 0;
   int          bad_count = 0;
   int          n_tests = 0;

   capture_timer_setup u_capture_timer_setup
   (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .wb_cyc_i    (wb_cyc_i),
      .wb_stb_i    (wb_stb_i),
      .wb_we_i     (wb_we_i),
      .wb_adr_i    (wb_adr_i),
      .wb_sel_i    (wb_sel_i),
      .wb_dat_i    (wb_dat_i),
      .wb_dat_o    (wb_dat_o),
      .wb_ack_o    (wb_ack_o),
      .slow_osc_clk(slow_osc_clk),
      .capture_pin (capture_pin),
      .irq_request (irq_request)
   );

   // Clock, 4 ns period
   always #2 clk_sys = ~clk_sys;

   // Oscillator and pin stimulus, toggling every third cycle
   always @(posedge clk_sys)
   begin
      if (tick == 2)
      begin
         tick <= 0;
         if (osc_run) slow_osc_clk <= ~slow_osc_clk;
         if (pin_run) capture_pin <= ~capture_pin;
      end
      else
         tick <= tick + 1;
   end

   // Compare one value and count it
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One classic Wishbone cycle, held until ack
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      if (n >= 50) check("wb_ack_o", 32'h1, 32'h0);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0, q);
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Reset values and an unmapped place
   task automatic t_reset;
      logic [31:0] q;
      rd(`CTS_OFF_STANDBY, q);   check("standby", 32'h20, q);
      rd(`CTS_OFF_IRQ_CTRL, q);  check("irq_ctrl", 32'h0, q);
      rd(`CTS_OFF_IRQ_EN, q);    check("irq_en", 32'h0, q);
      rd(`CTS_OFF_MODE, q);      check("mode", 32'h0, q);
      rd(`CTS_OFF_COUNT_CTL, q); check("count_ctl", 32'h0, q);
      wr(8'hfc, 32'hff);
      rd(8'hfc, q);              check("unmapped", 32'h0, q);
      $display("test reset values done");
   endtask

   // Standby and run bit gate the counter
   task automatic t_run;
      logic [31:0] q;
      logic [31:0] p;
      wr(`CTS_OFF_MODE, 32'h80);
      wait_clk(20);
      rd(`CTS_OFF_COUNTER, q);   check("frozen_in_standby", 32'h0, q);
      wr(`CTS_OFF_MODE, 32'h00);
      wr(`CTS_OFF_STANDBY, 32'h00);
      wait_clk(20);
      rd(`CTS_OFF_COUNTER, q);   check("stopped_count", 32'h0, q);
      wr(`CTS_OFF_MODE, 32'h80);
      wait_clk(20);
      rd(`CTS_OFF_COUNTER, q);   check("counting", 32'h1, {31'h0, q != 0});
      wr(`CTS_OFF_MODE, 32'h00);
      rd(`CTS_OFF_COUNTER, p);
      wait_clk(10);
      rd(`CTS_OFF_COUNTER, q);   check("held_count", p, q);
      $display("test standby and run done");
   endtask

   // Wrap flag with its enable set and cleared
   task automatic t_wrap;
      logic [31:0] q;
      wr(`CTS_OFF_IRQ_EN, 32'h80);
      wr(`CTS_OFF_IRQ_CTRL, 32'h1);
      wr(`CTS_OFF_COUNTER, 32'hfffe);
      wr(`CTS_OFF_MODE, 32'h80);
      wait_clk(30);
      rd(`CTS_OFF_FLAGS, q);     check("wrap_flag", 32'h10, q & 32'h10);
      rd(`CTS_OFF_IRQ_CTRL, q);  check("pending", 32'h9, q);
      check("irq_wrap", 32'h1, {31'h0, irq_request});
      wr(`CTS_OFF_MODE, 32'h00);
      wr(`CTS_OFF_IRQ_EN, 32'h00);
      wr(`CTS_OFF_FLAGS, 32'h1f);
      wr(`CTS_OFF_COUNTER, 32'hfffe);
      wr(`CTS_OFF_MODE, 32'h80);
      wait_clk(30);
      rd(`CTS_OFF_FLAGS, q);     check("wrap_flag2", 32'h10, q & 32'h10);
      rd(`CTS_OFF_IRQ_CTRL, q);  check("no_pending", 32'h1, q);
      check("irq_masked", 32'h0, {31'h0, irq_request});
      wr(`CTS_OFF_MODE, 32'h00);
      wr(`CTS_OFF_FLAGS, 32'h1f);
      $display("test wrap done");
   endtask

   // Capture from the divided oscillator, level zero, then enabled
   task automatic t_capture;
      logic [31:0] q;
      logic [31:0] c;
      int          n;
      wr(`CTS_OFF_COUNTER, 32'h0);
      wr(`CTS_OFF_IRQ_EN, 32'h01);
      wr(`CTS_OFF_IRQ_CTRL, 32'h0);
      wr(`CTS_OFF_IO_CTL, 32'h04);
      wr(`CTS_OFF_MODE, 32'h80);
      pin_run <= 1'b1;
      wait_clk(600);
      rd(`CTS_OFF_FLAGS, q);     check("pin_ignored", 32'h0, q & 32'h1);
      osc_run <= 1'b1;
      n = 0;
      do
      begin
         rd(`CTS_OFF_FLAGS, q);
         n++;
      end
      while (q[0] !== 1'b1 && n < 800);
      check("capture_flag", 32'h1, q & 32'h1);
      check("irq_level0", 32'h0, {31'h0, irq_request});
      rd(`CTS_OFF_IRQ_CTRL, q);  check("pending_level0", 32'h0, q);
      rd(`CTS_OFF_GEN_A, q);
      rd(`CTS_OFF_COUNTER, c);
      check("capture_value", 32'h1, {31'h0, q != 0 && q <= c});
      wr(`CTS_OFF_FLAGS, 32'h01);
      wr(`CTS_OFF_IRQ_CTRL, 32'h4);
      n = 0;
      while (irq_request !== 1'b1 && n < 3000)
      begin
         @(posedge clk_sys);
         n++;
      end
      check("irq_capture", 32'h1, {31'h0, irq_request});
      rd(`CTS_OFF_IRQ_CTRL, q);  check("pending_set", 32'hc, q);
      wr(`CTS_OFF_IRQ_EN, 32'h00);
      wait_clk(3);
      rd(`CTS_OFF_IRQ_CTRL, q);  check("pending_masked", 32'h4, q);
      check("irq_off", 32'h0, {31'h0, irq_request});
      osc_run <= 1'b0;
      pin_run <= 1'b0;
      $display("test capture done");
   endtask

   // Pin falling edge with clear on A and buffering, then a divide-by-4 source
   task automatic t_modes;
      logic [31:0] q;
      wr(`CTS_OFF_COUNT_CTL, 32'h80);
      wr(`CTS_OFF_IO_CTL, 32'h0d);
      wr(`CTS_OFF_MODE, 32'h90);
      pin_run <= 1'b1;
      wait_clk(60);
      rd(`CTS_OFF_GEN_A, q);     check("pin_fall_gen_a", 32'h5, q);
      rd(`CTS_OFF_GEN_C, q);     check("buffer_gen_c", 32'h5, q);
      pin_run <= 1'b0;
      wr(`CTS_OFF_MODE, 32'h00);
      wr(`CTS_OFF_IO_CTL, 32'h00);
      wr(`CTS_OFF_COUNT_CTL, 32'h20);
      wr(`CTS_OFF_COUNTER, 32'h0);
      wr(`CTS_OFF_MODE, 32'h80);
      wait_clk(40);
      wr(`CTS_OFF_MODE, 32'h00);
      rd(`CTS_OFF_COUNTER, q);   check("div4_count", 32'h1, {31'h0, q >= 10 && q <= 11});
      $display("test modes done");
   endtask

   // Counts and verdict
   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Watchdog
   initial
   begin
      #200000;
      bad_count++;
      $display("BAD watchdog expected done seen timeout");
      results();
   end

   // Main sequence
   initial
   begin
      wait_clk(12);
      rst_n <= 1'b1;
      wait_clk(2);
      t_reset();
      t_run();
      t_wrap();
      t_capture();
      t_modes();
      results();
   end
endmodule
`default_nettype wire
